// >>> bench/bfs_monitor_checker.sv
// Port-level assertions for the bridge fault and stall monitor
`timescale 1ns/1ps
module bfs_monitor_checker #(
  parameter OCF_DELAY_NS = 2500
) (
  input wire clk,
  input wire chip_reset_low,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] lowSideOn,
  input wire [3:0] highSideOn,
  input wire [1:0] lowSenseOver,
  input wire [3:0] highCurrentOver,
  input wire stepIn,
  input wire [1:0] phaseDisable
);
  localparam int OCF_CYC = (OCF_DELAY_NS + 49) / 50;
  logic [15:0] cntA;
  logic [15:0] cntB;
  wire ocA = (lowSenseOver[0] && |lowSideOn[1:0]) || |(highCurrentOver[1:0] & highSideOn[1:0]);
  wire ocB = (lowSenseOver[1] && |lowSideOn[3:2]) || |(highCurrentOver[3:2] & highSideOn[3:2]);
  // Run length of unbroken overcurrent per phase
  always @(posedge clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      cntA <= 16'h0000;
      cntB <= 16'h0000;
    end else begin
      cntA <= ocA ? cntA + 16'h0001 : 16'h0000;
      cntB <= ocB ? cntB + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!chip_reset_low);
  sequence sWrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sClearCause;
    $past(stepIn) || $past(stepIn, 2) || s_axi_bvalid || $past(s_axi_bvalid);
  endsequence
  a_short_delay_a: assert property ($rose(phaseDisable[0]) |-> cntA >= OCF_CYC - 1)
    else $error("phase A disabled before the fault delay");
  a_short_delay_b: assert property ($rose(phaseDisable[1]) |-> cntB >= OCF_CYC - 1)
    else $error("phase B disabled before the fault delay");
  a_release_cause_a: assert property ($fell(phaseDisable[0]) |-> sClearCause)
    else $error("phase A re-enabled without step or fault reset");
  a_release_cause_b: assert property ($fell(phaseDisable[1]) |-> sClearCause)
    else $error("phase B re-enabled without step or fault reset");
  a_write_answer: assert property (sWrTaken |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
endmodule // bfs_monitor_checker

bind bfs_monitor bfs_monitor_checker #(.OCF_DELAY_NS(OCF_DELAY_NS)) u_bfs_monitor_checker (.*);

// >>> bench/bfs_winding_model.sv
// Behavioural motor windings and bridge comparators seen by the monitor
`timescale 1ns/1ps
module bfs_winding_model (
  input wire [3:0] lowSideOn,
  input wire [3:0] highSideOn,
  input wire [1:0] phaseDisable,
  input wire [3:0] shortSupply,
  input wire [3:0] shortGround,
  input wire [5:0] dacA,
  input wire [5:0] dacB,
  input wire openA,
  output wire [1:0] lowSenseOver,
  output wire [3:0] highCurrentOver,
  output wire [7:0] phaseCurrentA,
  output wire [7:0] phaseCurrentB
);
  // A disabled bridge carries no current, so its comparators relax
  wire [3:0] en = ~{{2{phaseDisable[1]}}, {2{phaseDisable[0]}}};
  wire [3:0] liveLow = lowSideOn & en & shortSupply;
  assign lowSenseOver = {|liveLow[3:2], |liveLow[1:0]};
  assign highCurrentOver = highSideOn & en & shortGround;
  // An open winding still leaks a small fixed current
  assign phaseCurrentA = openA ? 8'h50 : {dacA, 2'b11};
  assign phaseCurrentB = {dacB, 2'b11};
endmodule // bfs_winding_model

// >>> bench/testbench.sv
// Self-checking testbench for the bridge fault and stall monitor
`timescale 1ns/1ps
module testbench;
  logic clk, chip_reset_low, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, stepIn, openA;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, lowSideOn, highSideOn, shortSupply, shortGround;
  logic [31:0] s_axi_wdata;
  logic [1:0] pwmDir, pwmOn, pwmCycleStart;
  logic [5:0] dacA, dacB;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, stallDetected, faultIndicatorPin;
  wire [1:0] s_axi_bresp, s_axi_rresp, phaseDisable, shortedLoad, lowSenseOver;
  wire [31:0] s_axi_rdata;
  wire [3:0] highCurrentOver;
  wire [7:0] phaseCurrentA, phaseCurrentB;
  int n_errors = 0;
  int comparisons = 0;
  // Short delay 10 cycles and blank 2 cycles keep the run brief
  bfs_monitor #(.OCF_DELAY_NS(500), .OL_BLANK_NS(100)) u_bfs_monitor (.*);
  bfs_winding_model u_bfs_winding_model (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      finish_test();
    end
    s_axi_bready <= 1'b0;
    check("bresp", s_axi_bresp, 2'b00);
  endtask
  task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      finish_test();
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic expectReg(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axiRead(a, d, r);
    check(what, r, 2'b00);
    check(what, d, exp);
  endtask
  task automatic pulse(input int ph, input int n);
    repeat (n) begin
      pwmCycleStart <= 2'b01 << ph;
      @(posedge clk);
      pwmCycleStart <= 2'b00;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic stepPulse;
    stepIn <= 1'b1;
    repeat (3) @(posedge clk);
    stepIn <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_defaults;
    logic [31:0] d;
    logic [1:0] r;
    check("pin", faultIndicatorPin, 1'b1);
    expectReg("config", 4'h0, 32'h0000_0834);
    expectReg("fault", 4'h4, 32'h0000_0000);
    axiRead(4'h2, d, r);
    check("unmapped resp", r, 2'b10);
    check("unmapped data", d, 32'h0000_0000);
  endtask
  task automatic t_short_low;
    lowSideOn <= 4'b0001;
    shortSupply <= 4'b0001;
    repeat (5) @(posedge clk);
    shortSupply <= 4'b0000;
    repeat (12) @(posedge clk);
    check("glitch disable", phaseDisable, 2'b00);
    shortSupply <= 4'b0001;
    repeat (8) @(posedge clk);
    check("early disable", phaseDisable, 2'b00);
    repeat (4) @(posedge clk);
    check("disable", phaseDisable, 2'b01);
    check("pin low", faultIndicatorPin, 1'b0);
    expectReg("fault A+ low", 4'h4, 32'h0000_8002);
    stepIn <= 1'b1;
    repeat (3) @(posedge clk);
    check("retry enable", phaseDisable, 2'b00);
    repeat (12) @(posedge clk);
    check("retry disable", phaseDisable, 2'b01);
    stepIn <= 1'b0;
    expectReg("fault kept", 4'h4, 32'h0000_8002);
    shortSupply <= 4'b0000;
    stepPulse();
    check("step enable", phaseDisable, 2'b00);
    check("pin high", faultIndicatorPin, 1'b1);
    axiWrite(4'h0, 32'h0000_0834);
    expectReg("fault reset", 4'h4, 32'h0000_0000);
    lowSideOn <= 4'b0000;
  endtask
  task automatic t_short_dir;
    lowSideOn <= 4'b0011;
    pwmDir <= 2'b01;
    shortSupply <= 4'b0010;
    repeat (14) @(posedge clk);
    expectReg("fault A- low", 4'h4, 32'h0000_8008);
    shortSupply <= 4'b0000;
    lowSideOn <= 4'b0000;
    axiWrite(4'h0, 32'h0000_0834);
    check("write enable", phaseDisable, 2'b00);
  endtask
  task automatic t_shorted_load;
    highSideOn <= 4'b0100;
    lowSideOn <= 4'b1000;
    shortGround <= 4'b0100;
    shortSupply <= 4'b1000;
    repeat (14) @(posedge clk);
    check("shorted load", shortedLoad, 2'b10);
    check("disable B", phaseDisable, 2'b10);
    expectReg("fault B", 4'h4, 32'h0000_8090);
    shortGround <= 4'b0000;
    shortSupply <= 4'b0000;
    axiWrite(4'h0, 32'h0000_0834);
    repeat (2) @(posedge clk);
    check("enable B", phaseDisable, 2'b00);
    highSideOn <= 4'b0010;
    lowSideOn <= 4'b0010;
    shortGround <= 4'b0010;
    shortSupply <= 4'b0010;
    repeat (14) @(posedge clk);
    check("shorted load A", shortedLoad, 2'b01);
    expectReg("fault A", 4'h4, 32'h0000_800c);
    shortGround <= 4'b0000;
    shortSupply <= 4'b0000;
    axiWrite(4'h0, 32'h0000_0834);
    check("enable A", phaseDisable, 2'b00);
  endtask
  task automatic t_open_load;
    dacA <= 6'h28;
    openA <= 1'b1;
    pulse(0, 18);
    expectReg("leak above 30pct", 4'h4, 32'h0000_0000);
    axiWrite(4'h0, 32'h0000_083c);
    pulse(0, 18);
    expectReg("open A", 4'h4, 32'h0000_8100);
    expectReg("present", 4'h8, 32'h0000_0090);
    openA <= 1'b0;
    pulse(0, 2);
    expectReg("cleared", 4'h8, 32'h0000_0000);
    expectReg("open kept", 4'h4, 32'h0000_8100);
    dacA <= 6'h1f;
    openA <= 1'b1;
    axiWrite(4'h0, 32'h0000_083c);
    pulse(0, 18);
    expectReg("dac 31", 4'h4, 32'h0000_0000);
    openA <= 1'b0;
  endtask
  // Phase A ramps zero to full in 2 PWM cycles, phase B in 20, so phase B stalls
  task automatic t_stall;
    axiWrite(4'h0, 32'h0000_0835);
    dacA <= 6'h00;
    pulse(0, 1);
    dacA <= 6'h14;
    pulse(0, 2);
    dacA <= 6'h3f;
    pulse(0, 1);
    check("no stall", stallDetected, 1'b0);
    dacB <= 6'h00;
    pulse(1, 1);
    dacB <= 6'h14;
    pulse(1, 20);
    dacB <= 6'h3f;
    pulse(1, 1);
    check("stall", stallDetected, 1'b1);
    check("stall pin", faultIndicatorPin, 1'b0);
    expectReg("stall bit", 4'h4, 32'h0000_8400);
  endtask
  task automatic t_pwma;
    axiWrite(4'h0, 32'h0000_0836);
    pwmOn <= 2'b01;
    repeat (3) @(posedge clk);
    check("pwm pin high", faultIndicatorPin, 1'b1);
    pwmOn <= 2'b00;
    repeat (3) @(posedge clk);
    check("pwm pin low", faultIndicatorPin, 1'b0);
    axiWrite(4'h0, 32'h0000_0837);
    repeat (3) @(posedge clk);
    check("analog pin", faultIndicatorPin, 1'b1);
    axiWrite(4'h0, 32'h0000_0834);
    repeat (3) @(posedge clk);
    check("fault pin", faultIndicatorPin, 1'b1);
  endtask
  initial begin
    {chip_reset_low, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, stepIn, openA} = 8'h00;
    {s_axi_awaddr, s_axi_araddr, lowSideOn, highSideOn, shortSupply, shortGround} = 24'h000000;
    s_axi_wstrb = 4'hf;
    s_axi_wdata = 32'h0000_0000;
    {pwmDir, pwmOn, pwmCycleStart} = 6'h00;
    dacA = 6'h00;
    dacB = 6'h00;
    repeat (5) @(posedge clk);
    chip_reset_low <= 1'b1;
    @(posedge clk);
    t_defaults();
    t_short_low();
    t_short_dir();
    t_shorted_load();
    t_open_load();
    t_stall();
    t_pwma();
    finish_test();
  end
endmodule // testbench

// >>> hdl/bfs_monitor.v
// Bridge short, open-load and stall supervisor with an AXI4-Lite register file
// How it works
// - Low-side overcurrent flagged while a low-side FET conducts and sense comparator trips.
// - Overcurrent must last the whole fault delay; then set bit, pull pin, disable.
// - With both low sides on, the shorted connection follows the PWM direction state.
// - High-side overcurrent flagged while that FET conducts and its comparator trips.
// - Concurrent high and low short faults on a phase report a shorted load.
// - Delay timer starts on overcurrent, restarts if it vanishes, latches fault at end.
// - Faulty phase stays disabled until step rise, chip reset or diagnostic reset.
// - Step or fault reset clears the fault flag and re-enables; step keeps diagnostic bits.
// - A persisting short is retried on every retry chance and disabled again.
// - Open-load monitoring runs only while the phase DAC value exceeds 31.
// - Open-load threshold is a percentage of a selectable maximum phase current.
// - Open-load current check ignored during a blank time after each PWM start.
// - Open load declared when DAC above 31 and current low for over 15 cycles.
// - Bridge keeps driving; open-load fault clears on current above threshold or DAC below 32.
// - Open-load bits held until chip reset or a register write.
// - One PWM cycle counter per phase counts cycles during a zero to full rise.
// - At rise end compare with opposite phase's last count; set stall above compare value.
// - Diagnostic pin goes low on stall when stall is selected.
// - Phase A PWM-on can be routed to the diagnostic pin.
// - Without register access the block runs from reset defaults.
// - By default the pin shows the fault output flag, low on fault or disable.
// - Bit 15 of the diagnostic register is set when any fault bit is set.
`timescale 1ns/1ps
`include "bfs_defs.vh"

module bfs_monitor #(
  parameter OCF_DELAY_NS = `BFS_OCF_DELAY_NS,
  parameter OL_BLANK_NS = `BFS_OL_BLANK_NS,
  parameter CNT_W = 8
) (
  input wire clk,
  input wire chip_reset_low,
  input wire [`BFS_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`BFS_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] lowSideOn,
  input wire [3:0] highSideOn,
  input wire [1:0] lowSenseOver,
  input wire [3:0] highCurrentOver,
  input wire [1:0] pwmDir,
  input wire [1:0] pwmOn,
  input wire [1:0] pwmCycleStart,
  input wire [5:0] dacA,
  input wire [5:0] dacB,
  input wire [7:0] phaseCurrentA,
  input wire [7:0] phaseCurrentB,
  input wire stepIn,
  output reg [1:0] phaseDisable,
  output reg [1:0] shortedLoad,
  output reg stallDetected,
  output reg faultIndicatorPin
);

  // Connection order in the 4-bit FET and comparator vectors: 0 A plus, 1 A minus, 2 B plus, 3 B minus
  localparam integer OCF_CYCLES_RAW = (OCF_DELAY_NS + `BFS_CLK_PERIOD_NS - 1) / `BFS_CLK_PERIOD_NS;
  localparam integer OCF_CYCLES = (OCF_CYCLES_RAW < 1) ? 1 : OCF_CYCLES_RAW;
  localparam integer OLB_CYCLES_RAW = (OL_BLANK_NS + `BFS_CLK_PERIOD_NS - 1) / `BFS_CLK_PERIOD_NS;
  localparam integer OLB_CYCLES = (OLB_CYCLES_RAW < 1) ? 1 : OLB_CYCLES_RAW;
  localparam [15:0] OCF_LAST = OCF_CYCLES[15:0] - 16'h0001;
  localparam [15:0] OLB_LAST = OLB_CYCLES[15:0] - 16'h0001;

  // Picks which low-side FET of one bridge carries the blame
  function [1:0] lowAttr;
    input [1:0] lowOn;
    input dir;
    begin
      if (lowOn == 2'b11)
        lowAttr = dir ? 2'b10 : 2'b01;
      else
        lowAttr = lowOn;
    end
  endfunction

  function [7:0] olThreshold;
    input [1:0] mxi;
    input [1:0] ol;
    reg [31:0] mp;
    reg [31:0] op;
    reg [31:0] prod;
    begin
      mp = 32'd0;
      op = 32'd0;
      case (mxi)
        2'b00: mp = `BFS_MXI_PCT0;
        2'b01: mp = `BFS_MXI_PCT1;
        2'b10: mp = `BFS_MXI_PCT2;
        default: mp = `BFS_MXI_PCT3;
      endcase
      case (ol)
        2'b00: op = `BFS_OL_PCT0;
        2'b01: op = `BFS_OL_PCT1;
        2'b10: op = `BFS_OL_PCT2;
        default: op = `BFS_OL_PCT3;
      endcase
      prod = ({24'h000000, `BFS_CUR_FULL} * mp * op) / `BFS_PCT_SQ;
      olThreshold = prod[7:0];
    end
  endfunction

  function [CNT_W-1:0] absDiff;
    input [CNT_W-1:0] a;
    input [CNT_W-1:0] b;
    begin
      absDiff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // Register file state
  reg [1:0] diagSel_reg;
  reg [1:0] olSel_reg;
  reg [1:0] maxSel_reg;
  reg [5:0] stallCompare_reg;
  reg [7:0] shortFault_reg;
  reg [1:0] openLoadFlag_reg;
  reg stallFlag_reg;

  // Bus channel state
  reg awHave_reg;
  reg wHave_reg;
  reg [`BFS_ADDR_W-1:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  wire writeFire;
  wire writeMapped;
  wire diagReset;

  assign s_axi_awready = !awHave_reg && !s_axi_bvalid;
  assign s_axi_wready = !wHave_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign writeFire = awHave_reg && wHave_reg && !s_axi_bvalid;
  assign writeMapped = (awAddr_reg == `BFS_ADDR_CONFIG) || (awAddr_reg == `BFS_ADDR_FAULT) ||
    (awAddr_reg == `BFS_ADDR_STATUS) || (awAddr_reg == `BFS_ADDR_COUNTS);
  // Any mapped write resets the diagnostic bits, even with no byte enabled
  assign diagReset = writeFire && writeMapped;

  always @(posedge clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awAddr_reg <= {`BFS_ADDR_W{1'b0}};
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BFS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (writeFire) begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= writeMapped ? `BFS_RESP_OKAY : `BFS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration defaults let the block run with no register access at all
  always @(posedge clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      diagSel_reg <= `BFS_CFG_FAULT_INDICATOR_PIN_RST;
      olSel_reg <= `BFS_CFG_OL_RST;
      maxSel_reg <= `BFS_CFG_MXI_RST;
      stallCompare_reg <= `BFS_CFG_SC_RST;
    end else if (writeFire && awAddr_reg == `BFS_ADDR_CONFIG) begin
      if (wStrb_reg[0]) begin
        diagSel_reg <= wData_reg[`BFS_CFG_FAULT_INDICATOR_PIN_LSB +: 2];
        olSel_reg <= wData_reg[`BFS_CFG_OL_LSB +: 2];
        maxSel_reg <= wData_reg[`BFS_CFG_MXI_LSB +: 2];
      end
      if (wStrb_reg[1])
        stallCompare_reg <= wData_reg[`BFS_CFG_SC_LSB +: 6];
    end
  end

  // Overcurrent detection: two low-side sense detectors, four high-side detectors
  wire [5:0] overCurrent;
  assign overCurrent[0] = lowSenseOver[0] && (lowSideOn[0] || lowSideOn[1]);
  assign overCurrent[1] = lowSenseOver[1] && (lowSideOn[2] || lowSideOn[3]);
  assign overCurrent[5:2] = highCurrentOver & highSideOn;

  reg [15:0] ocTimer_reg [0:5];
  reg [5:0] ocConfirm;
  integer i, j, k, m, n, p, q;

  always @* begin
    for (i = 0; i < 6; i = i + 1)
      ocConfirm[i] = overCurrent[i] && (ocTimer_reg[i] == OCF_LAST);
  end

  // One delay timer per detector; each restarts whenever its overcurrent drops out early
  always @(posedge clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      for (j = 0; j < 6; j = j + 1)
        ocTimer_reg[j] <= 16'h0000;
    end else begin
      for (j = 0; j < 6; j = j + 1) begin
        if (!overCurrent[j])
          ocTimer_reg[j] <= 16'h0000;
        else if (ocTimer_reg[j] != OCF_CYCLES[15:0])
          ocTimer_reg[j] <= ocTimer_reg[j] + 16'h0001;
      end
    end
  end

  // Map confirmed events to short-fault bits: conn*2 is high side, conn*2+1 is low side
  wire [1:0] lowBlameA;
  wire [1:0] lowBlameB;
  wire [7:0] shortEvent;
  assign lowBlameA = ocConfirm[0] ? lowAttr(lowSideOn[1:0], pwmDir[0]) : 2'b00;
  assign lowBlameB = ocConfirm[1] ? lowAttr(lowSideOn[3:2], pwmDir[1]) : 2'b00;
  assign shortEvent = {lowBlameB[1], ocConfirm[5], lowBlameB[0], ocConfirm[4],
    lowBlameA[1], ocConfirm[3], lowBlameA[0], ocConfirm[2]};

  reg stepPrev_reg;
  wire stepRise;
  assign stepRise = stepIn && !stepPrev_reg;

  // Phase disable; a retry after each step lets a lasting short trip again
  wire [1:0] phaseShortEvent;
  assign phaseShortEvent = {|shortEvent[7:4], |shortEvent[3:0]};

  always @(posedge clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      stepPrev_reg <= 1'b0;
      phaseDisable <= 2'b00;
    end else begin
      stepPrev_reg <= stepIn;
      for (k = 0; k < 2; k = k + 1) begin
        if (phaseShortEvent[k])
          phaseDisable[k] <= 1'b1;
        else if (stepRise || diagReset)
          phaseDisable[k] <= 1'b0;
      end
    end
  end

  // Open-load monitor, per phase
  wire [7:0] olLevel;
  wire [11:0] dacBus;
  wire [15:0] curBus;
  assign olLevel = olThreshold(maxSel_reg, olSel_reg);
  assign dacBus = {dacB, dacA};
  assign curBus = {phaseCurrentB, phaseCurrentA};

  reg [15:0] olBlank_reg [0:1];
  reg [1:0] olExceeded_reg;
  reg [3:0] olCount_reg [0:1];
  reg [1:0] olPresent_reg;
  reg [1:0] olEvent;

  always @* begin
    for (m = 0; m < 2; m = m + 1)
      olEvent[m] = pwmCycleStart[m] && (dacBus[m*6 +: 6] > `BFS_DAC_OL_LIMIT) && !olExceeded_reg[m] &&
        (olCount_reg[m] == `BFS_OL_CYCLES);
  end

  always @(posedge clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      for (n = 0; n < 2; n = n + 1) begin
        olBlank_reg[n] <= 16'h0000;
        olCount_reg[n] <= 4'h0;
      end
      olExceeded_reg <= 2'b00;
      olPresent_reg <= 2'b00;
    end else begin
      for (n = 0; n < 2; n = n + 1) begin
        if (pwmCycleStart[n]) begin
          olBlank_reg[n] <= 16'h0000;
          olExceeded_reg[n] <= 1'b0;
          if (dacBus[n*6 +: 6] <= `BFS_DAC_OL_LIMIT || olExceeded_reg[n])
            olCount_reg[n] <= 4'h0;
          else if (olCount_reg[n] != `BFS_OL_CYCLES)
            olCount_reg[n] <= olCount_reg[n] + 4'h1;
        end else begin
          if (olBlank_reg[n] != OLB_CYCLES[15:0])
            olBlank_reg[n] <= olBlank_reg[n] + 16'h0001;
          else if (curBus[n*8 +: 8] > olLevel)
            olExceeded_reg[n] <= 1'b1;
        end
        if (olEvent[n])
          olPresent_reg[n] <= 1'b1;
        else if (dacBus[n*6 +: 6] <= `BFS_DAC_OL_LIMIT ||
                 (olBlank_reg[n] == OLB_CYCLES[15:0] && curBus[n*8 +: 8] > olLevel))
          olPresent_reg[n] <= 1'b0;
      end
    end
  end

  // Stall monitor: cycles per rise, compared across phases
  reg [1:0] rising_reg;
  reg [CNT_W-1:0] riseCount_reg [0:1];
  reg [CNT_W-1:0] lastCount_reg [0:1];
  reg [1:0] riseEnd;
  reg [1:0] stallEvent;

  always @* begin
    for (p = 0; p < 2; p = p + 1) begin
      riseEnd[p] = rising_reg[p] && (dacBus[p*6 +: 6] == `BFS_DAC_FULL);
      stallEvent[p] = riseEnd[p] &&
        (absDiff(riseCount_reg[p], lastCount_reg[1-p]) > {{(CNT_W-6){1'b0}}, stallCompare_reg});
    end
  end

  always @(posedge clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      rising_reg <= 2'b00;
      for (q = 0; q < 2; q = q + 1) begin
        riseCount_reg[q] <= {CNT_W{1'b0}};
        lastCount_reg[q] <= {CNT_W{1'b0}};
      end
    end else begin
      for (q = 0; q < 2; q = q + 1) begin
        if (dacBus[q*6 +: 6] == 6'h00) begin
          rising_reg[q] <= 1'b1;
          riseCount_reg[q] <= {CNT_W{1'b0}};
        end else if (riseEnd[q]) begin
          rising_reg[q] <= 1'b0;
          lastCount_reg[q] <= riseCount_reg[q];
        end else if (rising_reg[q] && pwmCycleStart[q] && riseCount_reg[q] != {CNT_W{1'b1}}) begin
          riseCount_reg[q] <= riseCount_reg[q] + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Sticky diagnostic bits; a new event beats a reset in the same cycle
  always @(posedge clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      shortFault_reg <= 8'h00;
      openLoadFlag_reg <= 2'b00;
      stallFlag_reg <= 1'b0;
    end else begin
      shortFault_reg <= (diagReset ? 8'h00 : shortFault_reg) | shortEvent;
      openLoadFlag_reg <= (diagReset ? 2'b00 : openLoadFlag_reg) | olEvent;
      stallFlag_reg <= (diagReset ? 1'b0 : stallFlag_reg) | (|stallEvent);
    end
  end

  wire [15:0] faultWord;
  wire anyFaultBit;
  wire faultOutputLow;
  assign anyFaultBit = (|shortFault_reg) || (|openLoadFlag_reg) || stallFlag_reg;
  assign faultWord = {anyFaultBit, 4'h0, stallFlag_reg, openLoadFlag_reg, shortFault_reg};
  // Live fault: disabled phase or open load still present
  assign faultOutputLow = (|phaseDisable) || (|olPresent_reg);

  // Outputs registered so the pin never glitches on a select change
  always @(posedge clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      faultIndicatorPin <= 1'b1;
      shortedLoad <= 2'b00;
      stallDetected <= 1'b0;
    end else begin
      shortedLoad[0] <= (|{shortFault_reg[3], shortFault_reg[1]}) && (|{shortFault_reg[2], shortFault_reg[0]});
      shortedLoad[1] <= (|{shortFault_reg[7], shortFault_reg[5]}) && (|{shortFault_reg[6], shortFault_reg[4]});
      stallDetected <= stallFlag_reg;
      case (diagSel_reg)
        `BFS_FAULT_INDICATOR_PIN_FAULT: faultIndicatorPin <= !faultOutputLow;
        `BFS_FAULT_INDICATOR_PIN_STALL: faultIndicatorPin <= !stallFlag_reg;
        `BFS_FAULT_INDICATOR_PIN_PWMA: faultIndicatorPin <= pwmOn[0];
        // The analog temperature mode has no digital source here; the pin rests high
        default: faultIndicatorPin <= 1'b1;
      endcase
    end
  end

  // Read channel
  always @(posedge clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `BFS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `BFS_RESP_OKAY;
      case (s_axi_araddr)
        `BFS_ADDR_CONFIG: s_axi_rdata <= {18'h00000, stallCompare_reg, 2'b00, maxSel_reg, olSel_reg, diagSel_reg};
        `BFS_ADDR_FAULT: s_axi_rdata <= {16'h0000, faultWord};
        `BFS_ADDR_STATUS: s_axi_rdata <= {24'h000000, faultOutputLow, stallFlag_reg, olPresent_reg,
          shortedLoad, phaseDisable};
        `BFS_ADDR_COUNTS: s_axi_rdata <= {{(16-CNT_W){1'b0}}, lastCount_reg[1], {(16-CNT_W){1'b0}}, lastCount_reg[0]};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `BFS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // bfs_monitor

// >>> include/bfs_defs.vh
// Constants for the bridge fault and stall monitor
`ifndef BFS_DEFS_VH
`define BFS_DEFS_VH

`define BFS_CLK_PERIOD_NS 50
`define BFS_OCF_DELAY_NS 2500
`define BFS_OL_BLANK_NS 1000

`define BFS_ADDR_W 4
`define BFS_ADDR_CONFIG 4'h0
`define BFS_ADDR_FAULT 4'h4
`define BFS_ADDR_STATUS 4'h8
`define BFS_ADDR_COUNTS 4'hc

`define BFS_RESP_OKAY 2'b00
`define BFS_RESP_SLVERR 2'b10

`define BFS_FAULT_INDICATOR_PIN_FAULT 2'b00
`define BFS_FAULT_INDICATOR_PIN_STALL 2'b01
`define BFS_FAULT_INDICATOR_PIN_PWMA 2'b10
`define BFS_FAULT_INDICATOR_PIN_ANALOG 2'b11

`define BFS_CFG_FAULT_INDICATOR_PIN_LSB 0
`define BFS_CFG_OL_LSB 2
`define BFS_CFG_MXI_LSB 4
`define BFS_CFG_SC_LSB 8
`define BFS_CFG_FAULT_INDICATOR_PIN_RST 2'b00
`define BFS_CFG_OL_RST 2'b01
`define BFS_CFG_MXI_RST 2'b11
`define BFS_CFG_SC_RST 6'h08

`define BFS_FAULT_FF 15
`define BFS_FAULT_ST 10
`define BFS_FAULT_OLB 9
`define BFS_FAULT_OLA 8

`define BFS_DAC_OL_LIMIT 6'h1f
`define BFS_DAC_FULL 6'h3f
`define BFS_OL_CYCLES 4'hf
`define BFS_CUR_FULL 8'hff

`define BFS_MXI_PCT0 50
`define BFS_MXI_PCT1 67
`define BFS_MXI_PCT2 75
`define BFS_MXI_PCT3 100
`define BFS_OL_PCT0 20
`define BFS_OL_PCT1 30
`define BFS_OL_PCT2 40
`define BFS_OL_PCT3 50
`define BFS_PCT_SQ 10000

`endif
